// ===== pkg/chi_pkg.sv
// Constants for the charger serial host interface: bus address, register
// map, field layout, reset values, timing figures and threshold codes.
// Assumes a 25 MHz system clock; nothing else depends on the surroundings.
package chi_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam longint unsigned CLK_HZ           = 64'd25_000_000;
  localparam longint unsigned SAFETY_HOURS     = 64'd12;
  localparam longint unsigned SAFETY_CYCLES    =
    SAFETY_HOURS * 64'd3600 * CLK_HZ;
  localparam longint unsigned WDOG_UNIT_S      = 64'd40;
  localparam longint unsigned WDOG_UNIT_CYCLES = WDOG_UNIT_S * CLK_HZ;

  // ----------------------------------------------------------------------
  // Bus framing
  // ----------------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR   = 7'h6A;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic       DIR_READ   = 1'b1;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_INPUT_LIMIT = 8'h00;
  localparam logic [7:0] OFS_BOOST_VIN   = 8'h01;
  localparam logic [7:0] OFS_KICK        = 8'h03;
  localparam logic [7:0] OFS_WDOG_CFG    = 8'h07;
  localparam logic [7:0] OFS_FAULT       = 8'h0C;
  localparam logic [7:0] OFS_LAST        = 8'h14;
  localparam logic [7:0] BEYOND_DATA     = 8'hFF;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int         HIZ_BIT       = 7;
  localparam int         PIN_EN_BIT    = 6;
  localparam int         KICK_BIT      = 6;
  localparam int         WDOG_LSB      = 4;
  localparam int         WDOG_FLAG_BIT = 7;
  localparam logic [7:0] INPUT_LIMIT_RST = 8'h08;
  localparam logic [7:0] BOOST_VIN_RST   = 8'h06;
  localparam logic [1:0] WDOG_PERIOD_RST = 2'h1;
  localparam logic [1:0] WDOG_OFF        = 2'h0;

  // ----------------------------------------------------------------------
  // Analog scale figures
  // ----------------------------------------------------------------------
  localparam logic [11:0] CURRENT_LIMIT_PIN_BASE_MA   = 12'h064;  // 100 mA
  localparam logic [11:0] CURRENT_LIMIT_PIN_STEP_MA   = 12'h032;  // 50 mA
  localparam logic [14:0] VOS_STEP_MV    = 15'h0064; // 100 mV
  localparam logic [14:0] VFLOOR_MIN_MV  = 15'h0F3C; // 3.9 V
  localparam logic [14:0] VFLOOR_MAX_MV  = 15'h3BC4; // 15.3 V
  localparam logic [13:0] HOT_CODE0      = 14'h0D93; // 34.75 % x100
  localparam logic [13:0] HOT_CODE1      = 14'h0EBF; // 37.75 % x100
  localparam logic [13:0] HOT_CODE2      = 14'h0C35; // 31.25 % x100
  localparam logic [13:0] COLD_CODE0     = 14'h1E14; // 77 % x100
  localparam logic [13:0] COLD_CODE1     = 14'h1F40; // 80 % x100

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_REGA = 3'b010,
    ST_WDAT = 3'b011,
    ST_RDAT = 3'b100,
    ST_ACK  = 3'b101,
    ST_MACK = 3'b110
  } chi_state_type;

endpackage : chi_pkg

// ===== src/chi_sync.sv
// Two-stage synchroniser, one per bit, for the serial bus pins.
// Assumes inputs are asynchronous to clk; the outputs are safe to use.
`timescale 1ns/100ps
module chi_sync
  import chi_pkg::*;
#(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  // ----------------------------------------------------------------------
  // Per-bit flop pairs; idle bus level is high, so reset to ones
  // ----------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_q, hold_q;
      always_ff @(posedge clk) begin
        if (!rstn) begin
          meta_q <= 1'b1;
          hold_q <= 1'b1;
        end else begin
          meta_q <= async_in[i];
          hold_q <= meta_q;
        end
      end
      // Each bit owns its flop pair and its own process, one per output bit
      assign sync_out[i] = hold_q;
    end
  endgenerate

endmodule : chi_sync

// ===== src/chi_host_if.sv
// Serial slave interface of the charger with register access and the
// host/default mode supervisor (watchdog and charge safety timer).
// Assumes the bus pins are open drain with external pull-ups and that the
// fault, detection and voltage inputs come from logic on clk.
//
// Behaviour
// - Data sampled on clock high, changed low
// - Start and stop framed by data edges
// - Eight bits, MSB first, then acknowledge
// - Slave may stretch clock between bytes; this one never stretches it
// - Receiver holds data low during ninth pulse
// - Seven-bit address then direction bit
// - Answer only to address 6A
// - Undefined register address gets not-acknowledge
// - Multi-byte access except fault register
// - Fault register latches, cleared by read
// - Thermistor fault field always live
// - Watchdog flag high in default mode
// - Power-on: default mode, registers default
// - Default mode charging under 12-hour timer
// - Any write enters host mode
// - Watchdog expiry resets most registers
// - Register 0x00 field layout and defaults
// - Detection overwrites input current limit
// - Boost hot and cold threshold selects
// - Input voltage floor offset, clamp, doubling
// - Reads above 0x14 return 0xFF
// - Standard and fast mode rates
`timescale 1ns/100ps
module chi_host_if
  import chi_pkg::*;
#(
  parameter longint unsigned SAFETY_LIMIT = SAFETY_CYCLES,
  parameter longint unsigned WDOG_UNIT    = WDOG_UNIT_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  input  wire logic [3:0]  fault_events,
  input  wire logic [2:0]  thermistor_fault,
  input  wire logic        detect_done,
  input  wire logic [5:0]  detect_limit,
  input  wire logic [13:0] input_voltage_floor,
  input  wire logic        vbus_above_6v,
  output logic             high_impedance_enable,
  output logic             current_pin_enable,
  output logic [11:0]      input_current_limit_ma,
  output logic [13:0]      boost_hot_threshold,
  output logic             boost_hot_protect_en,
  output logic [13:0]      boost_cold_threshold,
  output logic [14:0]      vfloor_mv,
  output logic             host_mode,
  output logic             charge_enable
);

  // ----------------------------------------------------------------------
  // Pin sampling and bus events
  // ----------------------------------------------------------------------
  logic [1:0] pins_s;
  logic       scl_prev_q, sda_prev_q;
  logic       scl_s, sda_s, scl_rise, scl_fall, bus_start, bus_stop;

  // Oversampling at 25 MHz leaves dozens of samples per 400 kHz bit
  chi_sync #(.W(2)) u_sync (
    .clk      (clk),
    .rstn     (rstn),
    .async_in ({scl_in, sda_in}),
    .sync_out (pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // Previous sample for edge finding
  always_ff @(posedge clk) begin
    if (!rstn) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  assign scl_rise  = scl_s && !scl_prev_q;
  assign scl_fall  = !scl_s && scl_prev_q;
  assign bus_start = scl_s && scl_prev_q && sda_prev_q && !sda_s;
  assign bus_stop  = scl_s && scl_prev_q && !sda_prev_q && sda_s;

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic [7:0] input_limit_control_q, boost_temp_and_vin_offset_q;
  logic [1:0] wdog_period_q;
  logic [3:0] fault_latch_q;
  logic       host_mode_q;
  logic       wr_pulse, fault_rd, wdog_expire, host_entry;
  logic [7:0] wr_addr, wr_data;

  // Read mux; bit 7 of the fault register is the mode, not latched
  function automatic logic [7:0] read_byte(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a > OFS_LAST) begin
      v = BEYOND_DATA;
    end else if (a == OFS_INPUT_LIMIT) begin
      v = input_limit_control_q;
    end else if (a == OFS_BOOST_VIN) begin
      v = boost_temp_and_vin_offset_q;
    end else if (a == OFS_WDOG_CFG) begin
      v[WDOG_LSB+1:WDOG_LSB] = wdog_period_q;
    end else if (a == OFS_FAULT) begin
      v = {!host_mode_q, fault_latch_q, thermistor_fault};
    end
    return v;
  endfunction : read_byte

  // ----------------------------------------------------------------------
  // Serial protocol engine
  // ----------------------------------------------------------------------
  chi_state_type state_q, nxt_q;
  logic [7:0]    shift_q, tx_q, ptr_q;
  logic [3:0]    cnt_q;
  logic          drive_q, rw_q, first_q, mnack_q;
  logic          addr_hit, reg_ok, wbyte_ok, rd_ok;
  logic [7:0]    rd_byte;

  assign addr_hit = shift_q[7:1] == DEV_ADDR;
  assign reg_ok   = shift_q <= OFS_LAST;
  // Fault register only as the first byte of an access
  assign wbyte_ok = (ptr_q <= OFS_LAST) &&
                    (first_q || ptr_q != OFS_FAULT);
  assign rd_ok    = first_q || ptr_q != OFS_FAULT;
  // Fault register past the first byte reads as zeros and is not cleared
  assign rd_byte  = rd_ok ? read_byte(ptr_q) : 8'h00;

  assign wr_pulse   = scl_fall && state_q == ST_WDAT &&
                      cnt_q == BYTE_BITS && wbyte_ok;
  assign wr_addr    = ptr_q;
  assign wr_data    = shift_q;
  assign host_entry = scl_fall && state_q == ST_ADDR &&
                      cnt_q == BYTE_BITS && addr_hit &&
                      shift_q[0] != DIR_READ;
  assign fault_rd   = scl_fall && ptr_q == OFS_FAULT && first_q &&
                      ((state_q == ST_ACK && nxt_q == ST_RDAT) ||
                       (state_q == ST_MACK && !mnack_q));

  // Byte engine; sample on rising clock, change data on falling clock
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      nxt_q   <= ST_IDLE;
      shift_q <= 8'h00;
      tx_q    <= 8'h00;
      ptr_q   <= 8'h00;
      cnt_q   <= 4'h0;
      drive_q <= 1'b0;
      rw_q    <= 1'b0;
      first_q <= 1'b0;
      mnack_q <= 1'b0;
    end else if (bus_start) begin
      state_q <= ST_ADDR;
      cnt_q   <= 4'h0;
      drive_q <= 1'b0;
    end else if (bus_stop) begin
      state_q <= ST_IDLE;
      drive_q <= 1'b0;
    end else if (scl_rise) begin
      if (state_q == ST_ADDR || state_q == ST_REGA ||
          state_q == ST_WDAT) begin
        shift_q <= {shift_q[6:0], sda_s};
        cnt_q   <= cnt_q + 4'h1;
      end else if (state_q == ST_RDAT) begin
        cnt_q <= cnt_q + 4'h1;
      end else if (state_q == ST_MACK) begin
        mnack_q <= sda_s;
      end
    end else if (scl_fall) begin
      unique case (state_q)
        ST_IDLE: begin
          drive_q <= 1'b0;
        end
        ST_ADDR: begin
          if (cnt_q == BYTE_BITS) begin
            if (addr_hit) begin
              rw_q    <= shift_q[0];
              drive_q <= 1'b1;
              state_q <= ST_ACK;
              nxt_q   <= (shift_q[0] == DIR_READ) ? ST_RDAT : ST_REGA;
              first_q <= 1'b1;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_REGA: begin
          if (cnt_q == BYTE_BITS) begin
            if (reg_ok) begin
              ptr_q   <= shift_q;
              drive_q <= 1'b1;
              state_q <= ST_ACK;
              nxt_q   <= ST_WDAT;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_WDAT: begin
          if (cnt_q == BYTE_BITS) begin
            if (wbyte_ok) begin
              ptr_q   <= ptr_q + 8'h01;
              first_q <= 1'b0;
              drive_q <= 1'b1;
              state_q <= ST_ACK;
              nxt_q   <= ST_WDAT;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          cnt_q   <= 4'h0;
          state_q <= nxt_q;
          if (nxt_q == ST_RDAT) begin
            tx_q    <= rd_byte;
            drive_q <= !rd_byte[7];
            ptr_q   <= ptr_q + 8'h01;
            first_q <= 1'b0;
          end else begin
            drive_q <= 1'b0;
          end
        end
        ST_RDAT: begin
          if (cnt_q == BYTE_BITS) begin
            drive_q <= 1'b0; // Release for the master's acknowledge
            state_q <= ST_MACK;
          end else begin
            tx_q    <= {tx_q[6:0], 1'b0};
            drive_q <= !tx_q[6];
          end
        end
        ST_MACK: begin
          if (mnack_q) begin
            state_q <= ST_IDLE;
          end else begin
            cnt_q   <= 4'h0;
            state_q <= ST_RDAT;
            tx_q    <= rd_byte;
            drive_q <= !rd_byte[7];
            ptr_q   <= ptr_q + 8'h01;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          drive_q <= 1'b0;
        end
      endcase
    end
  end

  // Pull-down only; clock is never stretched since data is always ready
  assign sda_out  = 1'b0;
  assign sda_oe_n = !drive_q;

  // ----------------------------------------------------------------------
  // Watchdog and mode
  // ----------------------------------------------------------------------
  logic [33:0] wdog_cnt_q;
  logic [33:0] wdog_limit;
  logic        kick;

  assign kick = wr_pulse && wr_addr == OFS_KICK && wr_data[KICK_BIT];
  assign wdog_limit  = 34'(wdog_period_q) * 34'(WDOG_UNIT);
  assign wdog_expire = host_mode_q && wdog_period_q != WDOG_OFF &&
                       wdog_cnt_q >= wdog_limit;

  // Counter restarts on any write or kick; period 00 stops it
  always_ff @(posedge clk) begin
    if (!rstn || !host_mode_q || kick || wr_pulse ||
        wdog_period_q == WDOG_OFF) begin
      wdog_cnt_q <= 34'h0;
    end else begin
      wdog_cnt_q <= wdog_cnt_q + 34'h1;
    end
  end

  // Host mode entry by write, leave on expiry; power-on is default mode
  always_ff @(posedge clk) begin
    if (!rstn) begin
      host_mode_q <= 1'b0;
    end else if (host_entry) begin
      host_mode_q <= 1'b1;
    end else if (wdog_expire) begin
      host_mode_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  // Detection wins over a host write of the current limit field
  always_ff @(posedge clk) begin
    if (!rstn) begin
      input_limit_control_q       <= INPUT_LIMIT_RST;
      boost_temp_and_vin_offset_q       <= BOOST_VIN_RST;
      wdog_period_q <= WDOG_PERIOD_RST;
    end else begin
      if (wdog_expire) begin
        input_limit_control_q[7:6]  <= INPUT_LIMIT_RST[7:6];
        boost_temp_and_vin_offset_q[7:5]  <= BOOST_VIN_RST[7:5];
        wdog_period_q <= WDOG_PERIOD_RST;
      end else if (wr_pulse) begin
        if (wr_addr == OFS_INPUT_LIMIT) begin
          input_limit_control_q <= wr_data;
        end
        if (wr_addr == OFS_BOOST_VIN) begin
          boost_temp_and_vin_offset_q <= wr_data;
        end
        if (wr_addr == OFS_WDOG_CFG) begin
          wdog_period_q <= wr_data[WDOG_LSB+1:WDOG_LSB];
        end
      end
      if (detect_done) begin
        input_limit_control_q[5:0] <= detect_limit;
      end
    end
  end

  // Faults accumulate; a read reloads with present faults so none is lost
  always_ff @(posedge clk) begin
    if (!rstn) begin
      fault_latch_q <= 4'h0;
    end else if (fault_rd) begin
      fault_latch_q <= fault_events;
    end else begin
      fault_latch_q <= fault_latch_q | fault_events;
    end
  end

  // ----------------------------------------------------------------------
  // Safety timer for default mode
  // ----------------------------------------------------------------------
  logic [49:0] safety_cnt_q;
  logic        safety_done_q;

  always_ff @(posedge clk) begin
    if (!rstn || host_mode_q) begin
      safety_cnt_q  <= 50'h0;
      safety_done_q <= 1'b0;
    end else if (safety_cnt_q >= 50'(SAFETY_LIMIT - 64'd1)) begin
      safety_done_q <= 1'b1;
    end else begin
      safety_cnt_q <= safety_cnt_q + 50'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Decoded outputs, registered
  // ----------------------------------------------------------------------
  logic [14:0] vos_mv, vsum;

  assign vos_mv = 15'(boost_temp_and_vin_offset_q[4:0]) * VOS_STEP_MV *
                  (vbus_above_6v ? 15'h2 : 15'h1);
  assign vsum   = 15'(input_voltage_floor) + vos_mv;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      high_impedance_enable  <= 1'b0;
      current_pin_enable     <= 1'b0;
      input_current_limit_ma <= 12'h000;
      boost_hot_threshold    <= 14'h0000;
      boost_hot_protect_en   <= 1'b0;
      boost_cold_threshold   <= 14'h0000;
      vfloor_mv              <= 15'h0000;
      host_mode              <= 1'b0;
      charge_enable          <= 1'b0;
    end else begin
      high_impedance_enable  <= input_limit_control_q[HIZ_BIT];
      current_pin_enable     <= input_limit_control_q[PIN_EN_BIT];
      input_current_limit_ma <= CURRENT_LIMIT_PIN_BASE_MA +
                                12'(input_limit_control_q[5:0]) * CURRENT_LIMIT_PIN_STEP_MA;
      unique case (boost_temp_and_vin_offset_q[7:6])
        2'b00: boost_hot_threshold <= HOT_CODE0;
        2'b01: boost_hot_threshold <= HOT_CODE1;
        2'b10: boost_hot_threshold <= HOT_CODE2;
        2'b11: boost_hot_threshold <= 14'h0000;
      endcase
      boost_hot_protect_en <= boost_temp_and_vin_offset_q[7:6] != 2'b11;
      boost_cold_threshold <= boost_temp_and_vin_offset_q[5] ? COLD_CODE1 : COLD_CODE0;
      vfloor_mv <= (vsum < VFLOOR_MIN_MV) ? VFLOOR_MIN_MV :
                   (vsum > VFLOOR_MAX_MV) ? VFLOOR_MAX_MV : vsum;
      host_mode     <= host_mode_q;
      charge_enable <= !safety_done_q;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence addr_end_s;
    scl_fall && !bus_start && !bus_stop &&
    state_q == ST_ADDR && cnt_q == BYTE_BITS;
  endsequence

  sequence rega_end_s;
    scl_fall && !bus_start && !bus_stop &&
    state_q == ST_REGA && cnt_q == BYTE_BITS;
  endsequence

  addr_ack_a: assert property (@(posedge clk) disable iff (!rstn)
    addr_end_s and addr_hit |=> drive_q && state_q == ST_ACK)
    else $error("matching address not acknowledged");
  addr_ignore_a: assert property (@(posedge clk) disable iff (!rstn)
    addr_end_s and !addr_hit |=> !drive_q && state_q == ST_IDLE)
    else $error("foreign address acknowledged");
  undef_nack_a: assert property (@(posedge clk) disable iff (!rstn)
    rega_end_s and !reg_ok |=> !drive_q && state_q == ST_IDLE)
    else $error("undefined register acknowledged");
  stop_idle_a: assert property (@(posedge clk) disable iff (!rstn)
    bus_stop |=> state_q == ST_IDLE && sda_oe_n)
    else $error("stop did not release bus");
  write_host_a: assert property (@(posedge clk) disable iff (!rstn)
    host_entry |=> host_mode_q ##1 host_mode)
    else $error("write did not enter host mode");
  expire_reset_a: assert property (@(posedge clk) disable iff (!rstn)
    wdog_expire && !host_entry && !detect_done |=>
      !host_mode_q && input_limit_control_q[7:6] == INPUT_LIMIT_RST[7:6] &&
      input_limit_control_q[5:0] == $past(input_limit_control_q[5:0]))
    else $error("watchdog expiry reset wrong fields");
  fault_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    fault_rd |=> fault_latch_q == $past(fault_events))
    else $error("fault register not cleared by read");
  detect_load_a: assert property (@(posedge clk) disable iff (!rstn)
    detect_done |=> input_limit_control_q[5:0] == $past(detect_limit))
    else $error("detected limit not loaded");
  beyond_ff_a: assert property (@(posedge clk) disable iff (!rstn)
    scl_fall && ptr_q > OFS_LAST &&
    ((state_q == ST_ACK && nxt_q == ST_RDAT) ||
     (state_q == ST_MACK && !mnack_q)) |=> tx_q == BEYOND_DATA)
    else $error("read beyond map not 0xFF");
  safety_stop_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(safety_done_q) |=> !charge_enable [*2])
    else $error("charging not stopped by safety timer");

endmodule : chi_host_if

// ===== verif/chi_master_model.sv
// Bus master model for the charger serial pins, four clocks a half bit.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/100ps
module chi_master_model (
  input  wire logic clk,
  input  wire logic sda_bus,
  output logic      scl,
  output logic      sda_m
);
  // ----------------------------------------------------------------
  // Pin sequences
  // ----------------------------------------------------------------
  // Released lines idle high through the pull-up
  initial scl = 1'b1;
  initial sda_m = 1'b1;
  // Half of the 320 ns link period, moves only on falling clk edges
  task automatic half();
    repeat (4) @(negedge clk);
  endtask : half
  // Start (a=1) or stop (a=0): data moves while the clock is high
  task automatic cond(input logic a);
    @(negedge clk);
    sda_m = a;
    half();
    scl = 1'b1;
    half();
    sda_m = ~a;
    half();
    if (a) scl = 1'b0;
  endtask : cond
  // Eight bits MSB first, then the ninth pulse; data settles a clk late
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      @(negedge clk);
      sda_m = (i > 0) ? tx[i-1] : ack_in;
      half();
      scl = 1'b1;
      half();
      if (i > 0) rx[i-1] = sda_bus;
      else ack = sda_bus;
      scl = 1'b0;
    end
  endtask : xfer
endmodule : chi_master_model

// ===== verif/test_chi_host_if.sv
// Self-checking bench for the charger serial host interface.
// Assumes the master model owns the pins; registers reached by bus only.
`timescale 1ns/100ps
module test_chi_host_if;
  import chi_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0, dd = 1'b0, v6 = 1'b0;
  logic [3:0]  fe = 4'h0;
  logic [5:0]  dl = 6'h00;
  logic [2:0]  tf = 3'h2;
  logic [13:0] vb = 14'h0FA0;
  logic        scl, sda_m, sda_oe_n, sda_out, hiz, pen, hpe, hm, ce, ak;
  logic [11:0] current_limit_pin;
  logic [13:0] hot, cold;
  logic [14:0] vfl;
  logic [7:0]  rx;
  logic [13:0] hc [3] = '{HOT_CODE0, HOT_CODE1, HOT_CODE2};
  int          n_fail = 0, comparisons = 0, cyc = 0;
  // Open-drain data line with pull-up, low whoever pulls
  wire sda = sda_m & (sda_oe_n | sda_out);
  always #20 clk = ~clk;
  chi_host_if #(.SAFETY_LIMIT(200), .WDOG_UNIT(2000)) dut (
    .clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .fault_events(fe),
    .thermistor_fault(tf), .detect_done(dd), .detect_limit(dl),
    .input_voltage_floor(vb), .vbus_above_6v(v6),
    .high_impedance_enable(hiz), .current_pin_enable(pen),
    .input_current_limit_ma(current_limit_pin), .boost_hot_threshold(hot),
    .boost_hot_protect_en(hpe), .boost_cold_threshold(cold),
    .vfloor_mv(vfl), .host_mode(hm), .charge_enable(ce));
  chi_master_model m (.clk(clk), .sda_bus(sda), .scl(scl), .sda_m(sda_m));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  // Hang guard, well above the few thousand cycles the tests take
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 15000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR t=%0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task automatic cw(input int n);
    repeat (n) @(negedge clk);
  endtask : cw
  task automatic put(input logic [7:0] b, input logic ea);
    m.xfer(b, 1'b1, rx, ak);
    chk(ak, ea);
  endtask : put
  // Master acknowledges all but the last byte, which it refuses
  task automatic get(input logic last, input logic [7:0] e);
    m.xfer(8'hFF, last, rx, ak);
    chk(rx, e);
  endtask : get
  task automatic wr(input logic [7:0] ra, input logic [7:0] d);
    m.cond(1'b1);
    put({DEV_ADDR, 1'b0}, 1'b0);
    put(ra, 1'b0);
    put(d, 1'b0);
  endtask : wr
  // Register address in a write phase, then repeated start to read
  task automatic rsel(input logic [7:0] ra);
    m.cond(1'b1);
    put({DEV_ADDR, 1'b0}, 1'b0);
    put(ra, 1'b0);
    m.cond(1'b1);
    put({DEV_ADDR, DIR_READ}, 1'b0);
  endtask : rsel
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_defaults();
    chk(hm, 1'b0);
    chk(current_limit_pin, 12'h1F4);
    chk(pen, 1'b0);
    rsel(8'h00);
    get(1'b0, 8'h08);
    get(1'b1, 8'h06);
    m.cond(1'b0);
    chk({hm, ce}, 2'h3);
    $display("t_defaults done");
  endtask : t_defaults
  // Faults latch until read; thermistor bits stay live
  task automatic t_fault();
    fe = 4'h5;
    cw(2);
    fe = 4'h0;
    rsel(8'h0C);
    get(1'b1, 8'h2A);
    m.cond(1'b0);
    tf = 3'h5;
    rsel(8'h0C);
    get(1'b1, 8'h05);
    m.cond(1'b0);
    $display("t_fault done");
  endtask : t_fault
  task automatic t_write();
    wr(8'h00, 8'hC5);
    put(8'hE3, 1'b0);
    m.cond(1'b0);
    chk({hm, hiz, hpe}, 3'h6);
    chk(current_limit_pin, 12'h15E);
    chk(cold, 14'h1F40);
    chk(vfl, 15'h10CC);
    v6 = 1'b1;
    cw(4);
    chk(vfl, 15'h11F8);
    vb = 14'h0BB8;
    cw(4);
    chk(vfl, 15'h0F3C);
    vb = 14'h3A98;
    cw(4);
    chk(vfl, 15'h3BC4);
    vb = 14'h0FA0;
    for (int k = 0; k < 3; k++) begin
      wr(8'h01, {k[1:0], 6'h06});
      m.cond(1'b0);
      chk({hpe, hot, cold}, {1'b1, hc[k], 14'h1E14});
    end
    rsel(8'h00);
    get(1'b0, 8'hC5);
    get(1'b1, 8'h86);
    m.cond(1'b0);
    $display("t_write done");
  endtask : t_write
  task automatic t_refuse();
    m.cond(1'b1);
    put({7'h6B, 1'b0}, 1'b1);
    m.cond(1'b0);
    m.cond(1'b1);
    put({DEV_ADDR, 1'b0}, 1'b0);
    put(8'h15, 1'b1);
    m.cond(1'b0);
    wr(8'h0B, 8'h00);
    put(8'h00, 1'b1);
    m.cond(1'b0);
    rsel(8'h14);
    get(1'b0, 8'h00);
    get(1'b1, 8'hFF);
    m.cond(1'b0);
    $display("t_refuse done");
  endtask : t_refuse
  // Detection overwrite, then watchdog expiry and the safety timer
  task automatic t_wdog();
    dl = 6'h3F;
    dd = 1'b1;
    cw(1);
    dd = 1'b0;
    cw(3);
    chk(current_limit_pin, 12'hCB2);
    // Kick fixes the moment the watchdog restarts counting
    wr(OFS_KICK, 8'h40);
    m.cond(1'b0);
    cw(1900);
    chk(hm, 1'b1);
    cw(150);
    chk({hm, hiz, pen, ce}, 4'h1);
    chk({current_limit_pin, vfl}, {12'hCB2, 15'h1450});
    cw(250);
    chk(ce, 1'b0);
    $display("t_wdog done");
  endtask : t_wdog
  initial begin
    cw(6);
    rstn = 1'b1;
    cw(3);
    t_defaults();
    t_fault();
    t_write();
    t_refuse();
    t_wdog();
    report_and_stop();
  end
endmodule : test_chi_host_if
